/* File: include/ptc_consts.svh */
// Timing and field constants for the prescaled timer/counter
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH
`define PTC_CNT_W 32
`define PTC_PRE_W 4
`define PTC_CNT_RESET 32'h0000_0000
`define PTC_CLK_HZ 25000000
`define PTC_FAST_HZ 16000000
`define PTC_SLOW_HZ 1000000
// Prescaler at or above this value gives a tick of 1 MHz or less
`define PTC_SLOW_MIN_PRE 4'h4
// Phase accumulator modulus, chosen so both peripheral rates are exact
`define PTC_ACC_MOD 25
`define PTC_FAST_STEP 16
`define PTC_SLOW_STEP 1
`endif

/* File: include/ptc_pkg.sv */
// Types shared by the prescaled timer/counter files
package ptc_pkg;
	typedef enum logic {
		PTC_MODE_TIMER,
		PTC_MODE_COUNTER
	} ptc_mode_type;

	typedef struct packed {
		ptc_mode_type mode;
		logic [3:0] prescale;
	} ptc_cfg_type;
endpackage

/* File: sim/testbench.sv */
// Self-checking bench for the prescaled timer/counter
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [3:0] p;
		int e;
		logic s;
	} ptc_row_type;
	logic clk_i = 0;
	logic rst_n_i = 0;
	ptc_pkg::ptc_cfg_type cfg = '0;
	logic start = 0, stop = 0, clear = 0, count = 0;
	logic [31:0] count_o;
	logic running_o, tick_o, slow_src_o;
	int n_errors = 0, n_tests = 0, cyc = 0, n;
	ptc_row_type rows [8];
	ptc_timer u_ptc_timer (.clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
		.start_i(start), .stop_i(stop), .clear_i(clear), .count_i(count),
		.count_o(count_o), .running_o(running_o), .tick_o(tick_o),
		.slow_src_o(slow_src_o));
	// 25 MHz clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard, well above the few thousand cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			n_errors++;
			print_verdict();
		end
	end
	// Clear and start in one edge, so every run begins from zero
	task go(input ptc_pkg::ptc_mode_type m, input logic [3:0] p);
		@(posedge clk_i);
		cfg.mode <= m;
		cfg.prescale <= p;
		clear <= 1;
		start <= 1;
		@(posedge clk_i);
		clear <= 0;
		start <= 0;
	endtask
	initial begin
		// Ticks in 400 cycles: 256 fast enables, 16 slow ones
		for (int i = 0; i < 8; i++)
			rows[i] = '{p: 4'(i), e: 256 >> i, s: (i >= 4)};
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1;
		@(negedge clk_i);
		chk(count_o, 32'h0);
		chk({31'h0, running_o}, 32'h0);
		chk({31'h0, tick_o}, 32'h0);
		foreach (rows[i]) begin
			go(ptc_pkg::PTC_MODE_TIMER, rows[i].p);
			n = 0;
			repeat (400) begin
				@(negedge clk_i);
				if (tick_o === 1'b1 && running_o === 1'b1)
					n++;
			end
			@(negedge clk_i);
			chk(count_o, 32'(n));
			chk({31'h0, slow_src_o}, {31'h0, rows[i].s});
			chk(32'(n + 1 >= rows[i].e && n <= rows[i].e + 1), 32'h1);
		end
		// Back-to-back count triggers, one count each
		go(ptc_pkg::PTC_MODE_COUNTER, 4'h0);
		count <= 1;
		repeat (10) @(posedge clk_i);
		count <= 0;
		@(negedge clk_i);
		chk(count_o, 32'ha);
		repeat (50) @(negedge clk_i);
		chk(count_o, 32'ha);
		@(posedge clk_i);
		stop <= 1;
		@(posedge clk_i);
		stop <= 0;
		count <= 1;
		@(posedge clk_i);
		count <= 0;
		@(negedge clk_i);
		chk(count_o, 32'ha);
		chk({31'h0, running_o}, 32'h0);
		// Clear and trigger together on a nonzero count: clear wins
		go(ptc_pkg::PTC_MODE_COUNTER, 4'h0);
		count <= 1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk(count_o, 32'h3);
		@(posedge clk_i);
		clear <= 1;
		@(posedge clk_i);
		count <= 0;
		clear <= 0;
		@(negedge clk_i);
		chk(count_o, 32'h0);
		// Reset in mid-run
		go(ptc_pkg::PTC_MODE_TIMER, 4'h0);
		repeat (20) @(posedge clk_i);
		rst_n_i <= 0;
		@(posedge clk_i);
		rst_n_i <= 1;
		@(negedge clk_i);
		chk(count_o, 32'h0);
		chk({31'h0, running_o}, 32'h0);
		// A start straight after reset is taken
		go(ptc_pkg::PTC_MODE_COUNTER, 4'h0);
		count <= 1;
		@(posedge clk_i);
		count <= 0;
		@(negedge clk_i);
		chk(count_o, 32'h1);
		print_verdict();
	end
endmodule

/* File: src/ptc_rate_gen.sv */
// Fractional divider making one-cycle enables at a peripheral clock rate
`timescale 1ns/1ps
`include "ptc_consts.svh"
module ptc_rate_gen #(
	parameter logic [5:0] STEP = 6'h10
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	output logic tick_o
);
	logic [5:0] acc_r;
	logic [5:0] acc_nxt;
	logic tick_r;
	logic tick_nxt;

	// Add STEP each cycle; a wrap past the modulus is one period
	always_comb begin
		acc_nxt = acc_r + STEP;
		tick_nxt = 1'b0;
		if (acc_nxt >= 6'(`PTC_ACC_MOD)) begin
			acc_nxt = acc_nxt - 6'(`PTC_ACC_MOD);
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			acc_r <= 6'h00;
			tick_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;
endmodule

/* File: src/ptc_timer.sv */
// Prescaled 32-bit timer/counter top level
`timescale 1ns/1ps
`include "ptc_consts.svh"
module ptc_timer (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire ptc_pkg::ptc_cfg_type cfg_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic clear_i,
	input wire logic count_i,
	output logic [`PTC_CNT_W-1:0] count_o,
	output logic running_o,
	output logic tick_o,
	output logic slow_src_o
);
	logic fast_en;
	logic slow_en;
	logic slow_sel;
	logic src_en;
	logic [14:0] div_r;
	logic [14:0] div_nxt;
	logic [3:0] shift;
	logic tick;
	logic run_r;
	logic run_nxt;
	logic [`PTC_CNT_W-1:0] cnt_r;
	logic [`PTC_CNT_W-1:0] cnt_nxt;

	// Enables standing for the 16 MHz and 1 MHz peripheral clocks
	ptc_rate_gen #(.STEP(6'(`PTC_FAST_STEP))) u_fast (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_o(fast_en)
	);
	ptc_rate_gen #(.STEP(6'(`PTC_SLOW_STEP))) u_slow (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.tick_o(slow_en)
	);

	// Slow source saves power; shift shrinks by four to keep the rate
	always_comb begin
		slow_sel = (cfg_i.prescale >= `PTC_SLOW_MIN_PRE);
		src_en = slow_sel ? slow_en : fast_en;
		shift = slow_sel ? (cfg_i.prescale - `PTC_SLOW_MIN_PRE)
			: cfg_i.prescale;
	end

	// Power-of-two divider; tick when low shift bits wrap to zero
	always_comb begin
		div_nxt = div_r;
		tick = 1'b0;
		if (run_r && cfg_i.mode == ptc_pkg::PTC_MODE_TIMER && src_en) begin
			div_nxt = div_r + 15'h0001;
			tick = ((div_nxt & ((15'h0001 << shift) - 15'h0001))
				== 15'h0000);
			if (tick) begin
				div_nxt = 15'h0000;
			end
		end
		if (clear_i || !run_r) begin
			div_nxt = 15'h0000;
		end
	end

	// Run state and counter; clear beats a same-cycle increment
	always_comb begin
		run_nxt = run_r;
		if (start_i) begin
			run_nxt = 1'b1;
		end
		if (stop_i) begin
			run_nxt = 1'b0;
		end
		cnt_nxt = cnt_r;
		case (cfg_i.mode)
			ptc_pkg::PTC_MODE_TIMER: begin
				if (tick) begin
					cnt_nxt = cnt_r + 32'h0000_0001;
				end
			end
			ptc_pkg::PTC_MODE_COUNTER: begin
				if (run_r && count_i) begin
					cnt_nxt = cnt_r + 32'h0000_0001;
				end
			end
			default: begin
				cnt_nxt = cnt_r;
			end
		endcase
		if (clear_i) begin
			cnt_nxt = `PTC_CNT_RESET;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			div_r <= 15'h0000;
			run_r <= 1'b0;
			cnt_r <= `PTC_CNT_RESET;
		end else begin
			div_r <= div_nxt;
			run_r <= run_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign count_o = cnt_r;
	assign running_o = run_r;
	assign tick_o = tick;
	assign slow_src_o = slow_sel;

	// Helper: cycles since the last fast enable; it saturates rather
	// than wrapping, so a stalled enable can never pass for a healthy
	// one after 256 quiet cycles
	logic [7:0] gap_r;
	logic [7:0] gap_nxt;
	always_comb begin
		gap_nxt = gap_r;
		if (fast_en) begin
			gap_nxt = 8'h00;
		end else if (gap_r != 8'hff) begin
			gap_nxt = gap_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			gap_r <= 8'h00;
		end else begin
			gap_r <= gap_nxt;
		end
	end

	// One slow enable period in clock cycles
	localparam int SLOW_CYC = `PTC_ACC_MOD;

	// Increment conditions used by the step checks below
	sequence s_timer_tick;
		tick && !clear_i && cfg_i.mode == ptc_pkg::PTC_MODE_TIMER;
	endsequence

	sequence s_count_trig;
		run_r && count_i && !clear_i
		&& cfg_i.mode == ptc_pkg::PTC_MODE_COUNTER;
	endsequence

	// A tick at the 1 MHz setting, where one slow enable is one tick
	sequence s_p4_tick;
		tick && cfg_i.prescale == `PTC_SLOW_MIN_PRE;
	endsequence

	// Counter steps by exactly one for each accepted increment
	a_timer_inc: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_timer_tick |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
		else $error("Counter did not advance on tick");
	a_count_inc: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_count_trig |=> cnt_r == $past(cnt_r) + 32'h0000_0001)
		else $error("Counter did not advance on trigger");

	// In counter mode or when stopped, nothing but a trigger or a clear moves the counter
	a_count_hold: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!count_i && !clear_i && cfg_i.mode == ptc_pkg::PTC_MODE_COUNTER
		|=> $stable(cnt_r))
		else $error("Counter mode moved without trigger");
	a_stop_hold: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		!run_r && !clear_i |=> $stable(cnt_r))
		else $error("Stopped counter moved");

	// Only reachable from all ones; no preload port exists, so the
	// plain 32-bit add is what really carries this behaviour
	a_wrap_zero: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		cnt_r == 32'hffff_ffff && (tick || (run_r && count_i
		&& cfg_i.mode == ptc_pkg::PTC_MODE_COUNTER)) && !clear_i
		|=> cnt_r == 32'h0000_0000)
		else $error("Counter did not wrap to zero");

	// Slow settings must tick only on a 1 MHz enable
	a_slow_tick: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		tick && cfg_i.prescale >= `PTC_SLOW_MIN_PRE |-> slow_en)
		else $error("Slow setting ticked off the slow enable");
	a_slow_period: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		slow_en |-> ##SLOW_CYC slow_en)
		else $error("Slow enable period wrong");

	// Fast enable runs 16 of 25 cycles: never two idle, never three on
	a_fast_rate: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		fast_en |-> ##[1:2] fast_en)
		else $error("Fast enable rate wrong");
	a_fast_burst: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		fast_en ##1 fast_en |=> !fast_en)
		else $error("Fast enable ran too long");
	a_fast_gap: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		gap_r < 8'h03)
		else $error("Fast enable stalled");

	// At 1 MHz the next tick follows exactly one slow period later
	a_p4_period: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		s_p4_tick |-> ##SLOW_CYC (tick || !run_r
		|| cfg_i.mode != ptc_pkg::PTC_MODE_TIMER
		|| cfg_i.prescale != `PTC_SLOW_MIN_PRE))
		else $error("One MHz tick period wrong");
	a_pre0_rate: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		run_r && !clear_i && cfg_i.prescale == 4'h0
		&& cfg_i.mode == ptc_pkg::PTC_MODE_TIMER && fast_en |-> tick)
		else $error("Prescale zero must tick every enable");
endmodule
